// ===== core/ptc_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
module ptc_top import ptc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        imbFreeze,
  input  wire logic        extClockPin,
  input  wire logic        modLoadPin,
  input  wire logic [15:0] timebaseIn1,
  input  wire logic [15:0] timebaseIn2,
  input  wire logic [15:0] timebaseIn3,
  input  wire logic [15:0] timebaseIn4,
  output logic      [5:0]  divClkOut,
  output logic      [15:0] tbBusA,
  output logic             tbBusAEn,
  output logic      [15:0] tbBusB,
  output logic             tbBusBEn,
  output logic      [2:0]  irqReqLevel,
  output logic      [3:0]  irqArbId,
  output logic      [7:0]  irqVectorBase,
  output logic             irq
);

  logic             waitReq_r;
  logic [31:0]      readData_r;
  logic [15:0]      cfg_r;
  logic [15:0]      psc_r;
  logic [1:0][15:0] ctl_r;
  logic [1:0][15:0] cnt_r;
  logic [1:0]       ovf_r;
  logic [1:0]       arm_r;
  logic [2:0]       ist_r;
  logic [2:0]       imsk_r;
  logic             irq_r;
  logic [1:0]       s1_r;
  logic [7:0]       s2_r;
  logic [5:0]       divClk_r;
  logic [5:0]       divClk_nxt;
  logic [2:0]       clkSync_r;
  logic [2:0]       ldSync_r;
  logic [15:0]      tbA_r;
  logic [15:0]      tbB_r;
  logic             tbAEn_r;
  logic             tbBEn_r;
  logic [2:0]       reqLevel_r;
  logic [3:0]       reqArb_r;
  logic [7:0]       vecBase_r;
  logic [15:0]      rdMux;
  logic [15:0]      tbMux;
  logic [1:0]       tick;
  logic [1:0]       ovfEv;
  logic [1:0]       ovfClr;
  logic [1:0]       scRd;
  logic [1:0][2:0]  lvl;
  logic             ldEv;
  logic             sel1;
  logic             halt;
  logic             pscActive;
  logic             s1Tick;
  logic             rdDone;
  logic             wrDone;
  logic             clkRise;
  logic             clkFall;
  logic             ldRise;
  logic             ldFall;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  function automatic logic lowOnes(input logic [7:0] v,
                                   input logic [3:0] n);
    logic [7:0] m;
    m = 8'hFF >> (4'h8 - n);
    return (v & m) == m;
  endfunction

  function automatic logic ctrTick(input ptc_clksrc_type code,
                                   input logic [5:0]     div,
                                   input logic           rise,
                                   input logic           fall);
    logic t;
    t = 1'b0;
    case (code)
      CS_PCLK1: t = div[0];
      CS_PCLK2: t = div[1];
      CS_PCLK3: t = div[2];
      CS_PCLK4: t = div[3];
      CS_PCLK5: t = div[4];
      CS_DIVIDED_CLOCK_SIX: t = div[5];
      CS_FALL:  t = fall;
      CS_RISE:  t = rise;
      default:  t = 1'b0;
    endcase
    return t;
  endfunction

  // bus slave: waitrequest drops for exactly one cycle per request
  assign rdDone = avs_read && !waitReq_r;
  assign wrDone = avs_write && !waitReq_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
    end else begin
      waitReq_r <= !((avs_read || avs_write) && waitReq_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_r <= 32'h0000_0000;
    end else if (avs_read && waitReq_r) begin
      readData_r <= {16'h0000, rdMux};
    end
  end

  always_comb begin
    case (cfg_r[CFG_TBRS_LO +: 2])
      2'b00:   tbMux = timebaseIn1;
      2'b01:   tbMux = timebaseIn2;
      2'b10:   tbMux = timebaseIn3;
      default: tbMux = timebaseIn4;
    endcase
  end

  always_comb begin
    rdMux = 16'h0000;
    case (avs_address)
      ADDR_CFG:  rdMux = cfg_r;
      ADDR_PSC:  rdMux = psc_r;
      ADDR_FSC:  rdMux = ctl_r[0] | {ovf_r[0], 15'h0000}
                         | {8'h00, clkSync_r[1], 7'h00};
      ADDR_MSC:  rdMux = ctl_r[1] | {ovf_r[1], 15'h0000}
                         | {8'h00, clkSync_r[1], ldSync_r[1],
                            6'h00};
      ADDR_IST:  rdMux = {13'h0000, ist_r};
      ADDR_IMSK: rdMux = {13'h0000, imsk_r};
      ADDR_FCNT: rdMux = cnt_r[0];
      ADDR_MCNT: rdMux = cnt_r[1];
      ADDR_TBR:  rdMux = tbMux;
      default:   rdMux = 16'h0000;
    endcase
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= CFG_RST;
      psc_r  <= PSC_RST;
      imsk_r <= 3'h0;
    end else if (wrDone) begin
      if (avs_address == ADDR_CFG) begin
        cfg_r <= mergeLanes(cfg_r, avs_writedata, avs_byteenable)
                 & CFG_WMASK;
      end
      if (avs_address == ADDR_PSC) begin
        psc_r <= mergeLanes(psc_r, avs_writedata, avs_byteenable)
                 & PSC_WMASK;
      end
      if (avs_address == ADDR_IMSK && avs_byteenable[0]) begin
        imsk_r <= avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= {SC_RST, SC_RST};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrDone && avs_address == SC_ADDR[i]) begin
          ctl_r[i] <= mergeLanes(ctl_r[i], avs_writedata, avs_byteenable)
                      & SC_WMASK[i];
        end
      end
    end
  end

  // global halt from stop, or from bus freeze when enabled
  assign halt = cfg_r[CFG_STOP]
                || (cfg_r[CFG_FRZ] && imbFreeze);

  // prescaler
  assign pscActive = psc_r[PSC_RUN] && !halt;
  assign s1Tick = psc_r[PSC_DIV3] ? (s1_r == S1_LAST_DIV3)
                                  : (s1_r == S1_LAST_DIV2);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 2'h0;
      s2_r <= 8'h00;
    end else if (!pscActive) begin
      s1_r <= 2'h0;
      s2_r <= 8'h00;
    end else begin
      s1_r <= s1Tick ? 2'h0 : s1_r + 2'h1;
      if (s1Tick) begin
        s2_r <= s2_r + 8'h01;
      end
    end
  end

  always_comb begin
    divClk_nxt = 6'h00;
    for (int k = 0; k < 5; k++) begin
      divClk_nxt[k] = s1Tick && lowOnes(s2_r, 4'(k));
    end
    divClk_nxt[5] = s1Tick && lowOnes(s2_r, DIVIDED_CLOCK_SIX_BASE_BITS
                    + {2'b00, psc_r[PSC_SEL_LO +: 2]});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divClk_r <= 6'h00;
    end else begin
      divClk_r <= pscActive ? divClk_nxt : 6'h00;
    end
  end

  // pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync_r <= 3'h0;
      ldSync_r  <= 3'h0;
    end else begin
      clkSync_r <= {clkSync_r[1:0], extClockPin};
      ldSync_r  <= {ldSync_r[1:0], modLoadPin};
    end
  end

  assign clkRise = clkSync_r[1] && !clkSync_r[2];
  assign clkFall = !clkSync_r[1] && clkSync_r[2];
  assign ldRise  = ldSync_r[1] && !ldSync_r[2];
  assign ldFall  = !ldSync_r[1] && ldSync_r[2];
  assign ldEv = !halt && ((ctl_r[1][SC_EDGP] && ldRise)
                || (ctl_r[1][SC_EDGN] && ldFall));

  // counters, overflow flags and their clear handshake
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tick[i] = ctrTick(ptc_clksrc_type'(ctl_r[i][SC_CLK_LO +: 3]),
                        divClk_r, clkRise, clkFall);
      ovfEv[i] = !halt && tick[i] && cnt_r[i] == CNT_TOP
                 && !(i == 1 && ldEv);
      scRd[i] = rdDone && avs_address == SC_ADDR[i];
      ovfClr[i] = wrDone && avs_address == SC_ADDR[i]
                  && avs_byteenable[1] && !avs_writedata[SC_OVF]
                  && arm_r[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {16'h0000, 16'h0000};
    end else if (!halt) begin
      for (int i = 0; i < 2; i++) begin
        if (i == 1 && ldEv) begin
          cnt_r[i] <= MOD_RELOAD;
        end else if (tick[i]) begin
          cnt_r[i] <= cnt_r[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= 2'b00;
      arm_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // a new overflow beats a clear in the same cycle
        ovf_r[i] <= ovfEv[i] || (ovf_r[i] && !ovfClr[i]);
        if (ovfClr[i]) begin
          arm_r[i] <= 1'b0;
        end else if (scRd[i]) begin
          arm_r[i] <= ovf_r[i];
        end
      end
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r[IST_FOVF]  <= ovfEv[0] || (ist_r[IST_FOVF] && !(wrDone
                          && avs_address == ADDR_IST && avs_byteenable[0]
                          && avs_writedata[IST_FOVF]));
      ist_r[IST_MOVF]  <= ovfEv[1] || (ist_r[IST_MOVF] && !(wrDone
                          && avs_address == ADDR_IST && avs_byteenable[0]
                          && avs_writedata[IST_MOVF]));
      ist_r[IST_MLOAD] <= ldEv || (ist_r[IST_MLOAD] && !(wrDone
                          && avs_address == ADDR_IST && avs_byteenable[0]
                          && avs_writedata[IST_MLOAD]));
      irq_r <= |(ist_r & imsk_r);
    end
  end

  // bus interrupt request: higher level wins, ties go to higher id
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl[i] = ovf_r[i] ? ctl_r[i][SC_IL_LO +: 3] : 3'h0;
    end
    sel1 = (lvl[1] > lvl[0]) || (lvl[1] == lvl[0]
           && ctl_r[1][SC_ARB3] && !ctl_r[0][SC_ARB3]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqLevel_r <= 3'h0;
      reqArb_r   <= 4'h0;
      vecBase_r  <= 8'h00;
    end else begin
      reqLevel_r <= sel1 ? lvl[1] : lvl[0];
      if ((sel1 ? lvl[1] : lvl[0]) != 3'h0) begin
        reqArb_r <= {ctl_r[sel1 ? 1 : 0][SC_ARB3],
                     cfg_r[CFG_ARB_LO +: 3]};
      end else begin
        reqArb_r <= 4'h0;
      end
      vecBase_r <= {cfg_r[CFG_VECT_LO +: 2], 6'h00};
    end
  end

  // time base buses; free counter takes a bus both try to drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbA_r   <= 16'h0000;
      tbB_r   <= 16'h0000;
      tbAEn_r <= 1'b0;
      tbBEn_r <= 1'b0;
    end else begin
      tbAEn_r <= ctl_r[0][SC_DRIVE_BUS_A] || ctl_r[1][SC_DRIVE_BUS_A];
      tbBEn_r <= ctl_r[0][SC_DRIVE_BUS_B] || ctl_r[1][SC_DRIVE_BUS_B];
      tbA_r <= ctl_r[0][SC_DRIVE_BUS_A] ? cnt_r[0] :
               (ctl_r[1][SC_DRIVE_BUS_A] ? cnt_r[1] : 16'h0000);
      // driving both buses from one counter is legal but discouraged
      tbB_r <= ctl_r[0][SC_DRIVE_BUS_B] ? cnt_r[0] :
               (ctl_r[1][SC_DRIVE_BUS_B] ? cnt_r[1] : 16'h0000);
    end
  end

  assign avs_readdata    = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign divClkOut       = divClk_r;
  assign tbBusA          = tbA_r;
  assign tbBusAEn        = tbAEn_r;
  assign tbBusB          = tbB_r;
  assign tbBusBEn        = tbBEn_r;
  assign irqReqLevel     = reqLevel_r;
  assign irqArbId        = reqArb_r;
  assign irqVectorBase   = vecBase_r;
  assign irq             = irq_r;

  chk_stop_freezes_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfg_r[CFG_STOP] |=> $stable(cnt_r[0]) && $stable(cnt_r[1]))
    else $error("counter moved while stopped");

  chk_freeze_idles_psc: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_r[CFG_FRZ] && imbFreeze) |=> divClk_r == 6'h00)
    else $error("prescaler ticked during freeze");

  chk_vector_base_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    rst_n |=> vecBase_r == {$past(cfg_r[12:11]), 6'h00})
    else $error("vector base wrong");

  chk_run_off_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !psc_r[PSC_RUN] |=> divClk_r == 6'h00 && s1_r == 2'h0)
    else $error("prescaler active while not running");

  chk_div3_spacing: assert property (
    @(posedge clk) disable iff (!rst_n)
    (divClk_r[0] && pscActive && psc_r[PSC_DIV3])
    ##1 (pscActive && psc_r[PSC_DIV3])[*2]
    |-> !divClk_r[0] ##1 divClk_r[0])
    else $error("first stage not dividing by three");

  chk_div2_spacing: assert property (
    @(posedge clk) disable iff (!rst_n)
    (divClk_r[0] && pscActive && !psc_r[PSC_DIV3])
    |=> !divClk_r[0] && !divClk_r[1])
    else $error("first stage not dividing by two");

  chk_overflow_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cnt_r[0] == 16'hFFFF && tick[0] && !halt) |=> ovf_r[0])
    else $error("overflow flag not set");

  chk_write_one_keeps: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ovf_r[0] && wrDone && avs_address == ADDR_FSC
     && avs_writedata[15]) |=> ovf_r[0])
    else $error("flag cleared by writing one");

  chk_req_needs_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    reqLevel_r != 3'h0 |-> $past(ovf_r[0] || ovf_r[1]))
    else $error("request without overflow flag");

  chk_bus_b_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_r[0][SC_DRIVE_BUS_B] && !ctl_r[0][SC_DRIVE_BUS_A])
    |=> tbBEn_r && tbB_r == $past(cnt_r[0]))
    else $error("bus b not driven by free counter");

  chk_fall_edge_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_r[0][2:0] == 3'b110 && clkFall && !halt
     && cnt_r[0] != 16'hFFFF) |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001)
    else $error("falling edge not counted");

  chk_load_reload: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_r[1][SC_EDGP] && ldRise && !halt) |=> cnt_r[1] == 16'h0000)
    else $error("load edge did not reload");

  chk_bus_answer: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("slave answer late");

endmodule // ptc_top

// ===== core/ptc_pkg.sv
// Notes on behaviour
// - stop bit set halts every counter and the prescaler; clear runs normally
// - freeze-response bit set halts timers while bus freeze is high, else ignored
// - vector base bits give base number 00, 40, 80 or C0 hex
// - arbitration id is three global bits plus one per-counter bit
// - time base register read selects one of four time base buses
// - prescaler run clear holds divider in reset, all divided ticks low
// - first stage ratio bit chooses divide by three (1) or two (0)
// - outputs one to five are stage ratio times 1..16; six by ratio bits
// - overflow flag reads one after counter overflow until cleared
// - interrupt level field: zero disables, one lowest to seven highest
// - drive bits select which time base bus carries the count
// - free counter status bit shows the synchronised clock pin level
// - clock select codes 0 to 5 pick prescaler ticks one to six
// - code 6 counts clock pin falling edges, code 7 rising edges
// - modulus counter status bits show clock pin and load pin levels
// - load edge bits: none, rising, falling or both edges reload
package ptc_pkg;

  localparam logic [5:0] ADDR_CFG  = 6'h00;
  localparam logic [5:0] ADDR_PSC  = 6'h04;
  localparam logic [5:0] ADDR_FSC  = 6'h08;
  localparam logic [5:0] ADDR_MSC  = 6'h0C;
  localparam logic [5:0] ADDR_IST  = 6'h10;
  localparam logic [5:0] ADDR_IMSK = 6'h14;
  localparam logic [5:0] ADDR_FCNT = 6'h18;
  localparam logic [5:0] ADDR_MCNT = 6'h1C;
  localparam logic [5:0] ADDR_TBR  = 6'h20;

  localparam int CFG_STOP    = 15;
  localparam int CFG_FRZ     = 14;
  localparam int CFG_VECT_LO = 11;
  localparam int CFG_ARB_LO  = 8;
  localparam int CFG_TBRS_LO = 0;
  localparam logic [15:0] CFG_RST   = 16'h1800;
  localparam logic [15:0] CFG_WMASK = 16'hDF03;

  localparam int PSC_RUN    = 3;
  localparam int PSC_DIV3   = 2;
  localparam int PSC_SEL_LO = 0;
  localparam logic [15:0] PSC_RST   = 16'h0000;
  localparam logic [15:0] PSC_WMASK = 16'h000F;

  localparam int SC_OVF    = 15;
  localparam int SC_IL_LO  = 12;
  localparam int SC_ARB3   = 11;
  localparam int SC_DRIVE_BUS_A   = 9;
  localparam int SC_DRIVE_BUS_B   = 8;
  localparam int SC_IN2    = 7;
  localparam int SC_IN1    = 6;
  localparam int SC_EDGN   = 5;
  localparam int SC_EDGP   = 4;
  localparam int SC_CLK_LO = 0;
  localparam logic [15:0] SC_RST = 16'h0000;
  localparam logic [1:0][15:0] SC_WMASK = {16'h7B37, 16'h7B07};
  localparam logic [1:0][5:0]  SC_ADDR  = {ADDR_MSC, ADDR_FSC};

  localparam int IST_FOVF  = 0;
  localparam int IST_MOVF  = 1;
  localparam int IST_MLOAD = 2;

  localparam logic [1:0] S1_LAST_DIV2 = 2'h1;
  localparam logic [1:0] S1_LAST_DIV3 = 2'h2;
  localparam logic [3:0] DIVIDED_CLOCK_SIX_BASE_BITS = 4'h5;
  localparam logic [15:0] CNT_TOP    = 16'hFFFF;
  localparam logic [15:0] MOD_RELOAD = 16'h0000;

  typedef enum logic [2:0] {
    CS_PCLK1 = 3'b000,
    CS_PCLK2 = 3'b001,
    CS_PCLK3 = 3'b010,
    CS_PCLK4 = 3'b011,
    CS_PCLK5 = 3'b100,
    CS_DIVIDED_CLOCK_SIX = 3'b101,
    CS_FALL  = 3'b110,
    CS_RISE  = 3'b111
  } ptc_clksrc_type;

endpackage

// ===== verif/ptc_host_model.sv
`timescale 1ns/10ps
module ptc_host_model (
  input  wire logic        clk,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);

  initial begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // request held until waitrequest is sampled low, then released
  task automatic access(input  logic        wr,
                        input  logic [5:0]  addr,
                        input  logic [15:0] data,
                        output logic [15:0] rdata,
                        output logic        ok);
    int i;
    ok = 1'b0;
    rdata = 16'h0000;
    avs_address    <= addr;
    avs_writedata  <= {16'h0000, data};
    avs_byteenable <= 4'h3;
    avs_write      <= wr;
    avs_read       <= !wr;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        rdata = avs_readdata[15:0];
      end
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

endmodule // ptc_host_model

// ===== verif/ptc_top_test.sv
`timescale 1ns/10ps
`define CHECK(got, exp) \
  begin \
    nTests++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module ptc_top_test import ptc_pkg::*;;

  logic             clk;
  logic             rst_n;
  logic [5:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [3:0]       avs_byteenable;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             imbFreeze;
  logic             extClockPin;
  logic             modLoadPin;
  logic [3:0][15:0] tbIn;
  logic [5:0]       divClkOut;
  logic [15:0]      tbBusA;
  logic [15:0]      tbBusB;
  logic [2:0]       irqReqLevel;
  logic [3:0]       irqArbId;
  logic             tbBusAEn;
  logic             tbBusBEn;
  logic             irq;
  logic [7:0]       irqVectorBase;
  int               failures;
  int               nTests;

  ptc_host_model host (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  ptc_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .imbFreeze(imbFreeze), .extClockPin(extClockPin),
    .modLoadPin(modLoadPin), .timebaseIn1(tbIn[0]), .timebaseIn2(tbIn[1]),
    .timebaseIn3(tbIn[2]), .timebaseIn4(tbIn[3]), .divClkOut(divClkOut),
    .tbBusA(tbBusA), .tbBusAEn(tbBusAEn), .tbBusB(tbBusB),
    .tbBusBEn(tbBusBEn), .irqReqLevel(irqReqLevel), .irqArbId(irqArbId),
    .irqVectorBase(irqVectorBase), .irq(irq));

  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d, output logic [15:0] r);
    logic ok;
    host.access(w, a, d, r, ok);
    if (ok !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic pulses(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      if (divClkOut !== 6'h00) cnt++;
    end
  endtask

  task automatic measure(input int k, output int per);
    int i;
    for (i = 0; i < 2000 && divClkOut[k] !== 1'b1; i++) @(posedge clk);
    if (i == 2000) begin
      failures++;
      print_verdict();
    end
    @(posedge clk);
    per = 1;
    for (i = 0; i < 2000 && divClkOut[k] !== 1'b1; i++) begin
      @(posedge clk);
      per++;
    end
    if (i == 2000) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic testRegs();
    logic [15:0] r;
    bus(1'b0, ADDR_CFG, 16'h0000, r);
    `CHECK(r, CFG_RST)
    `CHECK(irqVectorBase, 8'hC0)
    bus(1'b0, 6'h3C, 16'h0000, r);
    `CHECK(r, 16'h0000)
    wr(ADDR_CFG, 16'hFFFF);
    bus(1'b0, ADDR_CFG, 16'h0000, r);
    `CHECK(r, 16'hDF03)
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_CFG, 16'(v << 11));
      repeat (2) @(posedge clk);
      `CHECK(irqVectorBase, {2'(v), 6'h00})
    end
    wr(ADDR_CFG, 16'h0000);
  endtask

  task automatic testPrescaler();
    int c;
    int p;
    int e;
    wr(ADDR_PSC, 16'h0007);
    pulses(100, c);
    `CHECK(c, 0)
    for (int d = 0; d < 2; d++)
      for (int s = 0; s < 4; s++) begin
        wr(ADDR_PSC, 16'(8 + 4 * d + s));
        for (int k = 0; k < 6; k++) begin
          measure(k, p);
          e = (d == 1 ? 3 : 2) * (k < 5 ? (1 << k) : (32 << s));
          `CHECK(p, e)
        end
      end
  endtask

  task automatic testHalt();
    int c;
    wr(ADDR_PSC, 16'h0008);
    wr(ADDR_CFG, 16'h8000);
    repeat (4) @(posedge clk);
    pulses(100, c);
    `CHECK(c, 0)
    wr(ADDR_CFG, 16'h4000);
    imbFreeze <= 1'b1;
    repeat (4) @(posedge clk);
    pulses(100, c);
    `CHECK(c, 0)
    wr(ADDR_CFG, 16'h0000);
    pulses(100, c);
    `CHECK(c != 0, 1'b1)
    imbFreeze <= 1'b0;
  endtask

  task automatic testTbrAndPins();
    logic [15:0] r;
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_CFG, 16'(v));
      bus(1'b0, ADDR_TBR, 16'h0000, r);
      `CHECK(r, tbIn[v])
      extClockPin <= v[1];
      modLoadPin  <= v[0];
      repeat (5) @(posedge clk);
      bus(1'b0, ADDR_FSC, 16'h0000, r);
      `CHECK(r[SC_IN2], v[1])
      bus(1'b0, ADDR_MSC, 16'h0000, r);
      `CHECK({r[SC_IN2], r[SC_IN1]}, 2'(v))
    end
    wr(ADDR_CFG, 16'h0000);
    extClockPin <= 1'b0;
    modLoadPin  <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic testCounting();
    logic [15:0] c0;
    logic [15:0] c1;
    int          rt;
    for (int m = 6; m < 8; m++) begin
      wr(ADDR_FSC, 16'(m));
      bus(1'b0, ADDR_FCNT, 16'h0000, c0);
      extClockPin <= 1'b1;
      repeat (6) @(posedge clk);
      bus(1'b0, ADDR_FCNT, 16'h0000, c1);
      `CHECK(c1 - c0, (m == 7) ? 16'h0001 : 16'h0000)
      extClockPin <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b0, ADDR_FCNT, 16'h0000, c0);
      `CHECK(c0 - c1, (m == 6) ? 16'h0001 : 16'h0000)
    end
    for (int k = 0; k < 6; k++) begin
      rt = (k < 5) ? (2 << k) : 64;
      wr(ADDR_FSC, 16'(k));
      bus(1'b0, ADDR_FCNT, 16'h0000, c0);
      repeat (40 * rt) @(posedge clk);
      bus(1'b0, ADDR_FCNT, 16'h0000, c1);
      `CHECK((c1 - c0) >= 16'd40 && (c1 - c0) <= 16'd42, 1'b1)
    end
  endtask

  task automatic edgeStep(input logic lvl, input logic exp);
    logic [15:0] r;
    modLoadPin <= lvl;
    repeat (6) @(posedge clk);
    bus(1'b0, ADDR_IST, 16'h0000, r);
    `CHECK(r[IST_MLOAD], exp)
    wr(ADDR_IST, 16'h0004);
  endtask

  task automatic testLoadEdges();
    logic [15:0] r;
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_MSC, 16'(e << 4));
      edgeStep(1'b1, e[0]);
      edgeStep(1'b0, e[1]);
    end
    wr(ADDR_MSC, 16'h0010);
    wr(ADDR_IMSK, 16'h0000);
    modLoadPin <= 1'b1;
    repeat (6) @(posedge clk);
    `CHECK(irq, 1'b0)
    wr(ADDR_IMSK, 16'h0004);
    repeat (2) @(posedge clk);
    `CHECK(irq, 1'b1)
    wr(ADDR_IST, 16'h0004);
    repeat (2) @(posedge clk);
    `CHECK(irq, 1'b0)
    bus(1'b0, ADDR_IST, 16'h0000, r);
    `CHECK(r[IST_MLOAD], 1'b0)
    modLoadPin <= 1'b0;
  endtask

  task automatic testDrive();
    logic [15:0] c;
    // code 3 would put one count on both buses and is left out
    for (int v = 0; v < 3; v++) begin
      // falling-edge source with a quiet pin freezes the count
      wr(ADDR_FSC, 16'((v << 8) | 6));
      bus(1'b0, ADDR_FCNT, 16'h0000, c);
      repeat (2) @(posedge clk);
      `CHECK({tbBusAEn, tbBusBEn}, 2'(v))
      `CHECK(tbBusA, v[1] ? c : 16'h0000)
      `CHECK(tbBusB, v[0] ? c : 16'h0000)
    end
    `CHECK({irqReqLevel, irqArbId}, 7'h00)
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    imbFreeze = 1'b0;
    extClockPin = 1'b0;
    modLoadPin = 1'b0;
    tbIn = {16'hD004, 16'hC003, 16'hB002, 16'hA001};
    failures = 0;
    nTests = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    testRegs();
    testPrescaler();
    testHalt();
    testTbrAndPins();
    testCounting();
    testLoadEdges();
    testDrive();
    print_verdict();
  end

endmodule // ptc_top_test
